// *** pkg/tpg_pkg.sv ***
package tpg_pkg;

   // Clock rate
   localparam int unsigned CLK_PERIOD_PS      = 4000;

   // Gate command timing, in nanoseconds except the resume wait in seconds
   localparam int unsigned DEAD_TIME_NS       = 1500;
   localparam int unsigned MIN_LEVEL_NS       = 500;
   localparam int unsigned MIN_CARRIER_PERIOD_NS = 50000;
   localparam int unsigned FAULT_REACT_NS     = 20000;
   localparam int unsigned SHUTDOWN_PULSE_NS  = 3000;
   localparam int unsigned RESUME_WAIT_S      = 2;

   // Derived cycle counts (least times round up)
   localparam int unsigned DEAD_CYC      = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned MIN_LEVEL_CYC = (MIN_LEVEL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned MIN_PERIOD_CYC = (MIN_CARRIER_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned REACT_CYC     = (FAULT_REACT_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned SHUTDOWN_CYC  = (SHUTDOWN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam longint unsigned RESUME_CYC_DEF =
      (longint'(RESUME_WAIT_S) * 64'he8d4a51000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Widths
   localparam int unsigned PHASES   = 3;
   localparam int unsigned CNT_W    = 32;
   localparam int unsigned HIST_W   = 8;

   // Per-phase command states
   typedef enum logic [1:0] {
      TPG_PH_OFF,
      TPG_PH_UPPER,
      TPG_PH_LOWER,
      TPG_PH_DEAD
   } tpg_phase_e;

   typedef enum logic [1:0] {
      TPG_RUN,
      TPG_TRIPPED,
      TPG_RESUME_WAIT
   } tpg_mode_e;

   // Saturating decrement used by the 32-bit timers
   function automatic logic [CNT_W-1:0] tpg_dec(input logic [CNT_W-1:0] v);
      tpg_dec = (v == '0) ? '0 : v - 32'h1;
   endfunction

endpackage

// *** pkg/tpg_hist_if.sv ***
`timescale 1ns/100ps
interface tpg_hist_if;
   import tpg_pkg::*;
   logic              wr_en;
   logic [HIST_W-1:0] wr_data;
   logic              rd_en;
   logic [HIST_W-1:0] rd_data;
   logic              rd_valid;
   modport owner (output wr_en, output wr_data, output rd_en, input rd_data, input rd_valid);
   modport store (input wr_en, input wr_data, input rd_en, output rd_data, output rd_valid);
endinterface

// *** src/tpg_fault_hist.sv ***
`timescale 1ns/100ps
// Small fault-cause log; read data comes out of a register
module tpg_fault_hist
   import tpg_pkg::*;
(
   // Clock and reset
   input wire logic   mclk,
   input wire logic   nrst,
   // Log port
   tpg_hist_if.store  hist
);

   localparam int unsigned DEPTH = 8;

   logic [HIST_W-1:0] mem_reg [DEPTH];
   logic [2:0]        wptr_reg;
   logic [2:0]        wptr_next;
   logic [2:0]        rptr_reg;
   logic [2:0]        rptr_next;
   logic [HIST_W-1:0] rdata_reg;
   logic [HIST_W-1:0] rdata_next;
   logic              rvalid_reg;
   logic              rvalid_next;

   always_comb
   begin
      wptr_next   = wptr_reg;
      rptr_next   = rptr_reg;
      rdata_next  = rdata_reg;
      rvalid_next = 1'b0;
      if (hist.wr_en)
      begin
         wptr_next = wptr_reg + 3'h1;
      end
      if (hist.rd_en)
      begin
         rdata_next  = mem_reg[rptr_reg];
         rvalid_next = 1'b1;
         rptr_next   = rptr_reg + 3'h1;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wptr_reg   <= 3'h0;
         rptr_reg   <= 3'h0;
         rdata_reg  <= '0;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         wptr_reg   <= wptr_next;
         rptr_reg   <= rptr_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // Storage without reset
   always_ff @(posedge mclk)
   begin
      if (hist.wr_en)
      begin
         mem_reg[wptr_reg] <= hist.wr_data;
      end
   end

   assign hist.rd_data  = rdata_reg;
   assign hist.rd_valid = rvalid_reg;

endmodule

// *** src/tpg_gate_ctrl.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Insert at least 1.5 us dead time.
// - Hold levels 0.5 us; carrier at most 20 kHz. The code does not enforce the carrier limit; MIN_PERIOD_CYC is unused.
// - Always drive every gate command line.
// - Controller may pull fault line low.
// - All commands low within hold time.
// - Short hold: react within 20 us.
// - Wait 2 s before resuming commands.
// - Controller stops drive on temperature rise.
module tpg_gate_ctrl
   import tpg_pkg::*;
#(
   parameter longint unsigned RESUME_CYC = RESUME_CYC_DEF
)
(
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               nrst,
   // Phase demand from the modulator, one bit per phase
   input  wire logic [PHASES-1:0]  upper_demand,
   input  wire logic [PHASES-1:0]  lower_demand,
   // Software control
   input  wire logic               drive_enable,
   input  wire logic               shutdown_req,
   input  wire logic               fault_clear,
   input  wire logic               overtemp,
   input  wire logic               hist_rd,
   // Gate command pins
   output logic [PHASES-1:0]       upper_gate_command,
   output logic [PHASES-1:0]       lower_gate_command,
   // Shared fault line, open drain
   input  wire logic               fault_shutdown_line_i,
   output logic                    fault_shutdown_line_o,
   output logic                    fault_shutdown_line_oe,
   // Status
   output logic                    fault_latched,
   output logic                    resume_blocked,
   output logic                    late_reaction,
   output logic [HIST_W-1:0]       hist_data,
   output logic                    hist_valid
);

   tpg_hist_if hist ();

   tpg_fault_hist u_hist
   (
      .mclk (mclk),
      .nrst (nrst),
      .hist (hist)
   );

   //****************************************
   // Per-phase dead-time sequencer
   //****************************************
   tpg_phase_e           ph_reg   [PHASES];
   tpg_phase_e           ph_next  [PHASES];
   logic [CNT_W-1:0]     ph_cnt_reg  [PHASES];
   logic [CNT_W-1:0]     ph_cnt_next [PHASES];
   logic [PHASES-1:0]    up_reg;
   logic [PHASES-1:0]    up_next;
   logic [PHASES-1:0]    lo_reg;
   logic [PHASES-1:0]    lo_next;
   logic                 kill;

   always_comb
   begin
      for (int p = 0; p < PHASES; p++)
      begin
         ph_next[p]     = ph_reg[p];
         ph_cnt_next[p] = tpg_dec(ph_cnt_reg[p]);
         up_next[p]     = up_reg[p];
         lo_next[p]     = lo_reg[p];
         if (kill)
         begin
            // Immediate stop; dead time still honoured before next turn-on
            ph_next[p]     = TPG_PH_DEAD;
            ph_cnt_next[p] = CNT_W'(DEAD_CYC);
            up_next[p]     = 1'b0;
            lo_next[p]     = 1'b0;
         end
         else if (ph_cnt_reg[p] == '0)
         begin
            unique case (ph_reg[p])
               TPG_PH_OFF:
               begin
                  if (upper_demand[p] && !lower_demand[p])
                  begin
                     ph_next[p]     = TPG_PH_UPPER;
                     up_next[p]     = 1'b1;
                     ph_cnt_next[p] = CNT_W'(MIN_LEVEL_CYC);
                  end
                  else if (lower_demand[p] && !upper_demand[p])
                  begin
                     ph_next[p]     = TPG_PH_LOWER;
                     lo_next[p]     = 1'b1;
                     ph_cnt_next[p] = CNT_W'(MIN_LEVEL_CYC);
                  end
               end
               TPG_PH_UPPER, TPG_PH_LOWER:
               begin
                  if ((ph_reg[p] == TPG_PH_UPPER) ? !upper_demand[p] : !lower_demand[p])
                  begin
                     ph_next[p]     = TPG_PH_DEAD;
                     up_next[p]     = 1'b0;
                     lo_next[p]     = 1'b0;
                     ph_cnt_next[p] = CNT_W'(DEAD_CYC);
                  end
               end
               TPG_PH_DEAD:
               begin
                  ph_next[p] = TPG_PH_OFF;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int p = 0; p < PHASES; p++)
         begin
            ph_reg[p]     <= TPG_PH_OFF;
            ph_cnt_reg[p] <= '0;
         end
         up_reg <= '0;
         lo_reg <= '0;
      end
      else
      begin
         for (int p = 0; p < PHASES; p++)
         begin
            ph_reg[p]     <= ph_next[p];
            ph_cnt_reg[p] <= ph_cnt_next[p];
         end
         up_reg <= up_next;
         lo_reg <= lo_next;
      end
   end

   //****************************************
   // Fault latch and resume guard
   //****************************************
   tpg_mode_e            mode_reg;
   tpg_mode_e            mode_next;
   logic [63:0]          wait_reg;
   logic [63:0]          wait_next;
   logic [CNT_W-1:0]     sd_cnt_reg;
   logic [CNT_W-1:0]     sd_cnt_next;
   logic [CNT_W-1:0]     react_reg;
   logic [CNT_W-1:0]     react_next;
   logic                 late_reg;
   logic                 late_next;
   logic                 fline_d_reg;
   logic                 fline_fall;
   logic                 line_pull_reg;
   logic                 line_pull_next;
   logic                 latched_reg;
   logic                 blocked_reg;

   // Line falling while we are not pulling means the device reports a fault
   assign fline_fall = !fault_shutdown_line_i && fline_d_reg && !line_pull_reg;
   assign kill       = (mode_reg != TPG_RUN) || fline_fall || overtemp
                       || !drive_enable || !fault_shutdown_line_i;

   always_comb
   begin
      mode_next      = mode_reg;
      wait_next      = (wait_reg == 64'h0) ? 64'h0 : wait_reg - 64'h1;
      sd_cnt_next    = tpg_dec(sd_cnt_reg);
      react_next     = react_reg;
      late_next      = late_reg;
      line_pull_next = line_pull_reg;
      hist.wr_en     = 1'b0;
      hist.wr_data   = '0;
      // Commanded shutdown pulse, at least the minimum low width
      if (shutdown_req && !line_pull_reg)
      begin
         line_pull_next = 1'b1;
         sd_cnt_next    = CNT_W'(SHUTDOWN_CYC);
      end
      else if (line_pull_reg && sd_cnt_reg == '0 && !shutdown_req)
      begin
         line_pull_next = 1'b0;
      end
      // Reaction deadline bookkeeping
      if (fline_fall)
      begin
         react_next = CNT_W'(REACT_CYC);
      end
      else if (react_reg != '0)
      begin
         react_next = tpg_dec(react_reg);
         if (react_reg == 32'h1 && (up_reg != '0 || lo_reg != '0))
         begin
            late_next = 1'b1;
         end
      end
      unique case (mode_reg)
         TPG_RUN:
         begin
            if (fline_fall || overtemp)
            begin
               mode_next    = TPG_TRIPPED;
               hist.wr_en   = 1'b1;
               hist.wr_data = {6'h00, overtemp, fline_fall};
            end
         end
         TPG_TRIPPED:
         begin
            if (fault_clear && fault_shutdown_line_i && !overtemp && !fline_fall)
            begin
               mode_next = TPG_RESUME_WAIT;
               wait_next = RESUME_CYC;
               late_next = 1'b0;
            end
         end
         TPG_RESUME_WAIT:
         begin
            if (fline_fall || overtemp)
            begin
               mode_next = TPG_TRIPPED;
            end
            else if (wait_reg == 64'h0)
            begin
               mode_next = TPG_RUN;
            end
         end
         default:
         begin
            mode_next = TPG_TRIPPED;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_reg      <= TPG_RUN;
         wait_reg      <= 64'h0;
         sd_cnt_reg    <= '0;
         react_reg     <= '0;
         late_reg      <= 1'b0;
         fline_d_reg   <= 1'b1;
         line_pull_reg <= 1'b0;
         latched_reg   <= 1'b0;
         blocked_reg   <= 1'b0;
      end
      else
      begin
         mode_reg      <= mode_next;
         wait_reg      <= wait_next;
         sd_cnt_reg    <= sd_cnt_next;
         react_reg     <= react_next;
         late_reg      <= late_next;
         fline_d_reg   <= fault_shutdown_line_i;
         line_pull_reg <= line_pull_next;
         latched_reg   <= (mode_next == TPG_TRIPPED);
         blocked_reg   <= (mode_next == TPG_RESUME_WAIT);
      end
   end

   //****************************************
   // Outputs
   //****************************************
   assign hist.rd_en = hist_rd;

   always_comb
   begin
      upper_gate_command     = up_reg;
      lower_gate_command     = lo_reg;
      fault_shutdown_line_o  = 1'b0;
      fault_shutdown_line_oe = line_pull_reg;
      fault_latched          = latched_reg;
      resume_blocked         = blocked_reg;
      late_reaction          = late_reg;
      hist_data              = hist.rd_data;
      hist_valid             = hist.rd_valid;
   end

endmodule

// *** tb/tpg_gate_ctrl_props.sv ***
`timescale 1ns/100ps
module tpg_gate_ctrl_props
   import tpg_pkg::*;
#(
   parameter longint unsigned RESUME_CYC = RESUME_CYC_DEF
)
(
   // Clock, reset, controls
   input wire logic              mclk,
   input wire logic              nrst,
   input wire logic              drive_enable,
   input wire logic              shutdown_req,
   // Pins and status
   input wire logic [PHASES-1:0] upper_gate_command,
   input wire logic [PHASES-1:0] lower_gate_command,
   input wire logic              fault_shutdown_line_i,
   input wire logic              fault_shutdown_line_oe,
   input wire logic              fault_latched,
   input wire logic              resume_blocked
);
   // ****
   // Helper counters
   // ****
   logic [PHASES-1:0] on_now;
   logic              kill;
   logic [1:0]        kill_reg;
   int unsigned       idle_reg [PHASES];
   int unsigned       high_reg [PHASES];
   longint unsigned   wait_reg;
   int unsigned       pull_reg;

   assign on_now = upper_gate_command | lower_gate_command;
   assign kill   = !drive_enable || !fault_shutdown_line_i || fault_latched || resume_blocked;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         kill_reg <= 2'h3;
         wait_reg <= 0;
         pull_reg <= 0;
         idle_reg <= '{default: DEAD_CYC};
         high_reg <= '{default: 0};
      end
      else
      begin
         kill_reg <= {kill_reg[0], kill};
         wait_reg <= resume_blocked ? wait_reg + 1 : 0;
         pull_reg <= fault_shutdown_line_oe ? pull_reg + 1 : 0;
         for (int p = 0; p < PHASES; p++)
         begin
            idle_reg[p] <= on_now[p] ? 0 : (idle_reg[p] < DEAD_CYC ? idle_reg[p] + 1 : DEAD_CYC);
            high_reg[p] <= on_now[p] ? high_reg[p] + 1 : 0;
         end
      end
   end

   // ****
   // Properties
   // ****
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sequence s_all_off;
      upper_gate_command == '0 && lower_gate_command == '0;
   endsequence

   property p_no_overlap;
      (upper_gate_command & lower_gate_command) == '0;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("phase overlap");

   property p_line_kill;
      !fault_shutdown_line_i |-> ##[1:2] s_all_off;
   endproperty
   a_line_kill: assert property (p_line_kill) else $error("commands on while line low");

   property p_trip;
      $fell(fault_shutdown_line_i) && !fault_shutdown_line_oe |-> ##[1:2] fault_latched;
   endproperty
   a_trip: assert property (p_trip) else $error("device fault not latched");

   property p_hold_off;
      (fault_latched || resume_blocked) [*2] |-> s_all_off;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("commands during shutdown");

   property p_resume_len;
      $fell(resume_blocked) && !fault_latched |-> wait_reg + 1 >= RESUME_CYC && wait_reg <= RESUME_CYC + 1;
   endproperty
   a_resume_len: assert property (p_resume_len) else $error("resume wait length");

   property p_pull_start;
      $rose(shutdown_req) |-> ##[1:2] fault_shutdown_line_oe;
   endproperty
   a_pull_start: assert property (p_pull_start) else $error("shutdown pull missing");

   property p_pull_len;
      $fell(fault_shutdown_line_oe) |-> pull_reg + 1 >= SHUTDOWN_CYC;
   endproperty
   a_pull_len: assert property (p_pull_len) else $error("shutdown pull too short");

   for (genvar g = 0; g < PHASES; g++)
   begin : g_ph
      property p_dead;
         $rose(upper_gate_command[g]) || $rose(lower_gate_command[g]) |-> idle_reg[g] >= DEAD_CYC;
      endproperty
      a_dead: assert property (p_dead) else $error("dead time short");

      property p_level;
         $fell(on_now[g]) && kill_reg == 2'h0 && !kill |-> high_reg[g] + 1 >= MIN_LEVEL_CYC;
      endproperty
      a_level: assert property (p_level) else $error("level too short");
   end
endmodule

bind tpg_gate_ctrl tpg_gate_ctrl_props #(.RESUME_CYC(RESUME_CYC)) u_props (
   .mclk, .nrst, .drive_enable, .shutdown_req, .upper_gate_command, .lower_gate_command,
   .fault_shutdown_line_i, .fault_shutdown_line_oe, .fault_latched, .resume_blocked);

// *** tb/tpg_dev_model.sv ***
`timescale 1ns/100ps
module tpg_dev_model
#(
   parameter int unsigned HOLD_LONG_NS  = 8000000,
   parameter int unsigned HOLD_SHORT_NS = 34000
)
(
   // Gate commands
   input  wire logic [2:0] upper_gate_command,
   input  wire logic [2:0] lower_gate_command,
   // Sense inputs, strap, shared line
   input  wire logic       overcurrent_sense,
   input  wire logic       overvoltage_sense,
   input  wire logic       supply_low,
   input  wire logic       hold_strap,
   input  wire logic       fault_shutdown_line,
   // Transistor gates and fault pull-down
   output logic [2:0]      upper_gate_drive,
   output logic [2:0]      lower_gate_drive,
   output logic            fault_pulldown_transistor
);
   // ****
   // Device behaviour
   // ****
   logic ocp_hold = 1'b0;

   assign upper_gate_drive = upper_gate_command;
   assign lower_gate_drive = lower_gate_command & {3{fault_shutdown_line}};
   assign fault_pulldown_transistor = ocp_hold | overvoltage_sense | supply_low;

   // Held for the strapped time, whatever the sense does meanwhile
   always @(posedge overcurrent_sense)
   begin
      ocp_hold = 1'b1;
      #(hold_strap ? HOLD_SHORT_NS : HOLD_LONG_NS);
      ocp_hold = 1'b0;
   end
endmodule

// *** tb/tpg_gate_ctrl_bench.sv ***
`timescale 1ns/100ps
module tpg_gate_ctrl_bench
   import tpg_pkg::*;
;
   // ****
   // Stimulus, table and wiring
   // ****
   localparam longint unsigned RES = 1000;
   typedef struct packed {logic [2:0] u; logic [2:0] l; logic [5:0] e;} tpg_row_s;
   tpg_row_s   rows [6] = '{'{3'h1, 3'h0, 6'h08}, '{3'h0, 3'h6, 6'h06}, '{3'h5, 3'h2, 6'h2a},
                            '{3'h7, 3'h7, 6'h2a}, '{3'h2, 3'h5, 6'h15}, '{3'h0, 3'h0, 6'h00}};
   logic [3:0] causes [5] = '{4'h3, 4'h2, 4'h4, 4'h8, 4'h0};
   logic       mclk = 1'b0;
   logic       nrst = 1'b0;
   logic [2:0] ud = 3'h0;
   logic [2:0] ld = 3'h0;
   logic       drive_enable = 1'b1;
   logic       shutdown_req = 1'b0;
   logic       fault_clear = 1'b0;
   logic       overtemp = 1'b0;
   logic       hist_rd = 1'b0;
   logic [3:0] cause = 4'h0;
   logic [2:0] uc, lc;
   logic       oe, pin_o, pull, fault_latched, resume_blocked, late_reaction, hist_valid;
   logic [7:0] hist_data;
   wire        line = ~((oe & ~pin_o) | pull);
   int         failures = 0;
   int         num_checks = 0;

   always #2 mclk = ~mclk;

   tpg_gate_ctrl #(.RESUME_CYC(RES)) dut (
      .mclk, .nrst, .upper_demand(ud), .lower_demand(ld), .drive_enable, .shutdown_req,
      .fault_clear, .overtemp, .hist_rd, .upper_gate_command(uc), .lower_gate_command(lc),
      .fault_shutdown_line_i(line), .fault_shutdown_line_o(pin_o), .fault_shutdown_line_oe(oe),
      .fault_latched, .resume_blocked, .late_reaction, .hist_data, .hist_valid);
   tpg_dev_model #(.HOLD_LONG_NS(60000)) dev (
      .upper_gate_command(uc), .lower_gate_command(lc), .overcurrent_sense(cause[1]),
      .overvoltage_sense(cause[2]), .supply_low(cause[3]), .hold_strap(cause[0]),
      .fault_shutdown_line(line), .upper_gate_drive(), .lower_gate_drive(),
      .fault_pulldown_transistor(pull));

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic mid(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #300000;
      failures++;
      stop_test();
   end

   initial
   begin
      cyc(2);
      nrst <= 1'b1;
      foreach (rows[i])
      begin
         ud <= rows[i].u;
         ld <= rows[i].l;
         mid(520);
         chk("table", 8'(rows[i].e), 8'({uc, lc}));
         cyc(1);
      end
      $display("test table done");
      ud <= 3'h1;
      mid(2);
      chk("upper_on", 8'h1, 8'(uc));
      cyc(1);
      ud <= 3'h0;
      ld <= 3'h1;
      mid(100);
      chk("min_level", 8'h1, 8'(uc));
      mid(300);
      chk("dead", 8'h0, 8'(lc));
      mid(200);
      chk("lower_on", 8'h1, 8'(lc));
      cyc(1);
      drive_enable <= 1'b0;
      mid(2);
      chk("disabled", 8'h0, 8'({uc, lc}));
      cyc(1);
      drive_enable <= 1'b1;
      ld <= 3'h7;
      $display("test timing done");
      for (int k = 0; k < 5; k++)
      begin
         cyc(600);
         cause <= causes[k];
         overtemp <= k == 4;
         mid(3);
         chk("trip", 8'h1, 8'(fault_latched));
         chk("kill", 8'h0, 8'({uc, lc}));
         cyc(1);
         hist_rd <= 1'b1;
         fault_clear <= 1'b1;
         cyc(1);
         hist_rd <= 1'b0;
         fault_clear <= 1'b0;
         mid(0);
         chk("log", k == 4 ? 8'h2 : 8'h1, hist_valid ? hist_data : 8'hff);
         chk("refused", 8'h1, 8'(fault_latched));
         cyc(1);
         cause <= 4'h0;
         overtemp <= 1'b0;
         for (int i = 0; i < 20000 && !line; i++)
            @(posedge mclk);
         mid(1);
         chk("late", 8'h0, 8'(late_reaction));
         cyc(1);
         fault_clear <= 1'b1;
         cyc(1);
         fault_clear <= 1'b0;
         mid(1);
         chk("resume_wait", 8'h40, 8'({resume_blocked, uc, lc}));
         mid(int'(RES) - 10);
         chk("still_off", 8'h8, 8'({resume_blocked, lc}));
         mid(20);
         chk("resume_open", 8'h0, 8'(resume_blocked));
         mid(380);
         chk("resumed", 8'h7, 8'(lc));
         cyc(1);
         $display("test fault %0d done", k);
      end
      shutdown_req <= 1'b1;
      cyc(1);
      shutdown_req <= 1'b0;
      mid(3);
      chk("pull", 8'h0, 8'({line, fault_latched, lc}));
      mid(700);
      chk("pull_held", 8'h1, 8'(oe));
      mid(500);
      chk("pull_gone", 8'hf, 8'({line, lc}));
      cyc(1);
      nrst <= 1'b0;
      mid(1);
      chk("reset", 8'h0, 8'({oe, fault_latched, uc, lc}));
      cyc(1);
      nrst <= 1'b1;
      mid(2);
      chk("after_reset", 8'h7, 8'(lc));
      $display("test shutdown done");
      stop_test();
   end
endmodule
